// ===== rtl/sbrg_pkg.sv
/*
  Shared constants and types of the serial baud rate generator.
  Assumes a single system clock; all users import the whole package.
*/
package sbrg_pkg;

  // ********************************************************
  // Register map (word index on the plain register port)
  // ********************************************************
  localparam logic [2:0] SBRG_ADDR_BAUD_CONTROL = 3'h0;
  localparam logic [2:0] SBRG_ADDR_RX_STATUS = 3'h1;
  localparam logic [2:0] SBRG_ADDR_DIV_LOW = 3'h2;
  localparam logic [2:0] SBRG_ADDR_DIV_HIGH = 3'h3;
  localparam logic [2:0] SBRG_ADDR_TX_STATUS = 3'h4;
  localparam logic [2:0] SBRG_ADDR_IRQ_STATUS = 3'h5;
  localparam logic [2:0] SBRG_ADDR_IRQ_MASK = 3'h6;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int SBRG_BC_OVF = 7;
  localparam int SBRG_BC_IDLE = 6;
  localparam int SBRG_BC_POL = 4;
  localparam int SBRG_BC_WIDE = 3;
  localparam int SBRG_BC_WAKE = 1;
  localparam int SBRG_BC_ABD = 0;
  localparam int SBRG_RC_SPEN = 7;
  localparam int SBRG_TX_SYNC = 4;
  localparam int SBRG_TX_HIGH = 2;
  localparam int SBRG_IRQ_WAKE = 0;
  localparam int SBRG_IRQ_ABD_DONE = 1;
  localparam int SBRG_IRQ_ABD_OVF = 2;

  // ********************************************************
  // Reset values and counts
  // ********************************************************
  localparam logic [7:0] SBRG_RST_REG = 8'h00;
  localparam logic [7:0] SBRG_BC_WR_MASK = 8'h1b;
  localparam logic [2:0] SBRG_IRQ_BITS = 3'h7;
  localparam logic [5:0] SBRG_PRE_LOW64 = 6'h3f;
  localparam logic [5:0] SBRG_PRE_MID16 = 6'h0f;
  localparam logic [5:0] SBRG_PRE_FAST4 = 6'h03;
  localparam logic [2:0] SBRG_ABD_EDGES = 3'h4;
  localparam int SBRG_ABD_SHIFT = 3;

  // Mode bits that steer the timer and the pin
  typedef struct packed {
    logic spen;
    logic sync;
    logic high_speed;
    logic wide;
    logic polarity;
  } sbrg_cfg_t;

  // Auto-baud measurement states, Gray along the path
  typedef enum logic [1:0] {
    SBRG_ABD_IDLE = 2'b00,
    SBRG_ABD_WAIT = 2'b01,
    SBRG_ABD_MEAS = 2'b11
  } sbrg_abd_t;

endpackage

// ===== rtl/sbrg_count.sv
/*
  Wrapping up-counter used as prescaler and as baud timer.
  Assumes clear and enable are synchronous to clk_in.
*/
module sbrg_count #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic clr_in,
  input wire logic en_in,
  input wire logic [WIDTH-1:0] limit_in,
  // Status
  output logic wrap_out
);

  logic [WIDTH-1:0] cnt_q;

  // Wrap is combinational so the caller sees it in the same cycle
  assign wrap_out = en_in && !clr_in && (cnt_q == limit_in);

  // Count from zero up to the limit, then restart
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (clr_in || wrap_out) begin
      cnt_q <= '0;
    end else if (en_in) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // sbrg_count

// ===== rtl/sbrg_fall.sv
/*
  Falling edge detector for the receive line.
  Assumes the line is already synchronous to clk_in.
*/
module sbrg_fall (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Line and edge
  input wire logic line_in,
  output logic fall_out
);

  logic prev_q;

  // Line idles high, so reset to one avoids a false edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= line_in;
    end
  end

  assign fall_out = prev_q && !line_in;

endmodule // sbrg_fall

// ===== rtl/sbrg_top.sv
/*
  Baud rate generator and baud control logic of the enhanced serial unit.
  Assumes a plain register port (read data one cycle later), a receiver
  that reports busy, and a transmitter that consumes the baud tick.
*/
// Function
// - Overflow flag, bit 7, set on auto-baud timer overflow; read-only, resets 0.
// - Receiver idle flag, bit 6, reads 1 while idle, 0 while receiving.
// - Async: polarity 1 inverts transmit data on the transmit/clock pin.
// - Sync: polarity 1 clocks on rising edge, 0 on falling edge.
// - Baud timer is 8-bit by default, 16-bit with wide select bit 3.
// - Async: wake enable waits for falling edge, sets receive flag, then clears itself.
// - Async: auto-baud enable bit 0 starts detection; hardware clears it when done.
// - Divisor high gives bits 15:8, low gives bits 7:0 of timer period.
// - Async multiplier uses high-speed and wide bits; sync ignores high-speed.
// - Writing either divisor register clears the baud timer at once.
// - Rate Fosc/64(n+1) 8-bit slow, /16(n+1) 16-bit slow, /4(n+1) sync.
// - Baud control bits 5 and 2 read zero and ignore writes.
// - Sync select 1 chooses synchronous, 0 asynchronous operation.
// - Async high-speed select 1 picks fast multiplier, 0 the slow one.
module sbrg_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Receiver side
  input wire logic rx_in,
  input wire logic rx_busy_in,
  output logic receive_flag_out,
  // Transmitter side
  input wire logic tx_data_in,
  input wire logic sync_clk_in,
  output logic transmit_clock_pin_out,
  output logic clk_rise_out,
  // Baud tick and interrupt
  output logic baud_tick_out,
  output logic irq_out
);
  import sbrg_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [7:0] rx_status_q;
  logic [7:0] tx_status_q;
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic polarity_q;
  logic wide_q;
  logic wake_q;
  logic abd_en_q;
  logic abd_ovf_q;
  logic idle_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  sbrg_abd_t abd_state_q;
  logic [2:0] abd_edges_q;
  logic [15:0] abd_cnt_q;
  logic abd_done;
  logic abd_overflow;
  logic [15:0] abd_result;
  sbrg_cfg_t cfg;
  logic wr_bc;
  logic wr_div;
  logic rx_fall;
  logic pre_wrap;
  logic baud_wrap;
  logic [5:0] pre_limit;
  logic [15:0] baud_limit;
  logic timer_clr;

  // ********************************************************
  // Helper functions
  // ********************************************************

  // Prescale limit: one less than the period multiplier
  function automatic logic [5:0] mult_limit(input sbrg_cfg_t c);
    logic [5:0] lim;
    lim = SBRG_PRE_LOW64;
    if (c.sync) begin
      lim = SBRG_PRE_FAST4;
    end else if (c.wide && c.high_speed) begin
      lim = SBRG_PRE_FAST4;
    end else if (c.wide || c.high_speed) begin
      lim = SBRG_PRE_MID16;
    end
    return lim;
  endfunction

  // Register port decode, used by the write strobes; reads decode with a case
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction

  // ********************************************************
  // Mode bits and decodes
  // ********************************************************

  // Mode bits gathered for the timer and pin logic
  assign cfg.spen = rx_status_q[SBRG_RC_SPEN];
  assign cfg.sync = tx_status_q[SBRG_TX_SYNC];
  assign cfg.high_speed = tx_status_q[SBRG_TX_HIGH];
  assign cfg.wide = wide_q;
  assign cfg.polarity = polarity_q;

  // Write strobes of interest
  assign wr_bc = wr_in && hit(addr_in, SBRG_ADDR_BAUD_CONTROL);
  assign wr_div = wr_in && (hit(addr_in, SBRG_ADDR_DIV_LOW) ||
                           hit(addr_in, SBRG_ADDR_DIV_HIGH));

  // ********************************************************
  // Baud timer
  // ********************************************************

  // Timer limit: the divisor pair, high half dropped in 8-bit mode
  assign baud_limit = wide_q ? {div_high_q, div_low_q}
                             : {8'h00, div_low_q};
  assign pre_limit = mult_limit(cfg);

  // Divisor writes restart the count; disabled port holds it in reset
  assign timer_clr = wr_div || abd_done || !cfg.spen;

  // Prescaler gives the multiplier, timer gives the n+1 factor
  sbrg_count #(.WIDTH(6)) u_pre (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clr_in(timer_clr),
    .en_in(1'b1),
    .limit_in(pre_limit),
    .wrap_out(pre_wrap)
  );

  sbrg_count #(.WIDTH(16)) u_timer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clr_in(timer_clr),
    .en_in(pre_wrap),
    .limit_in(baud_limit),
    .wrap_out(baud_wrap)
  );

  // One-cycle tick per baud period
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      baud_tick_out <= 1'b0;
    end else begin
      baud_tick_out <= baud_wrap;
    end
  end

  // ********************************************************
  // Receive line edge
  // ********************************************************
  sbrg_fall u_fall (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .line_in(rx_in),
    .fall_out(rx_fall)
  );

  // ********************************************************
  // Auto-baud measurement
  // ********************************************************

  // A 0x55 frame gives five falling edges over eight bit times
  assign abd_done = (abd_state_q == SBRG_ABD_MEAS) && rx_fall &&
                    (abd_edges_q == SBRG_ABD_EDGES);
  assign abd_overflow = (abd_state_q == SBRG_ABD_MEAS) && pre_wrap &&
                        (abd_cnt_q == 16'hffff);
  // Eight bit times of prescaled ticks, divided down to n
  assign abd_result = (abd_cnt_q >> SBRG_ABD_SHIFT) - 16'h0001;

  // Measurement sequencer; ignored in synchronous mode
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abd_state_q <= SBRG_ABD_IDLE;
      abd_edges_q <= 3'h0;
      abd_cnt_q <= 16'h0000;
    end else begin
      case (abd_state_q)
        SBRG_ABD_IDLE: begin
          if (abd_en_q && !cfg.sync) begin
            abd_state_q <= SBRG_ABD_WAIT;
          end
        end
        SBRG_ABD_WAIT: begin
          abd_cnt_q <= 16'h0000;
          abd_edges_q <= 3'h0;
          if (!abd_en_q || cfg.sync) begin
            abd_state_q <= SBRG_ABD_IDLE;
          end else if (rx_fall) begin
            abd_state_q <= SBRG_ABD_MEAS;
            abd_edges_q <= 3'h1; // Start bit edge is the first of five
          end
        end
        SBRG_ABD_MEAS: begin
          if (pre_wrap) begin
            abd_cnt_q <= abd_cnt_q + 16'h0001;
          end
          if (rx_fall) begin
            abd_edges_q <= abd_edges_q + 3'h1;
          end
          if (abd_done || abd_overflow || !abd_en_q || cfg.sync) begin
            abd_state_q <= SBRG_ABD_IDLE;
          end
        end
        default: begin
          abd_state_q <= SBRG_ABD_IDLE;
        end
      endcase
    end
  end

  // Enable bit: software sets, hardware clears on completion
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abd_en_q <= 1'b0;
    end else if (abd_done || abd_overflow) begin
      abd_en_q <= 1'b0;
    end else if (wr_bc) begin
      abd_en_q <= wdata_in[SBRG_BC_ABD];
    end
  end

  // Overflow flag, read-only; cleared when a new detection starts
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abd_ovf_q <= 1'b0;
    end else if (abd_overflow) begin
      abd_ovf_q <= 1'b1;
    end else if (wr_bc && wdata_in[SBRG_BC_ABD]) begin
      abd_ovf_q <= 1'b0;
    end
  end

  // ********************************************************
  // Wake on edge and receiver idle
  // ********************************************************

  // Wake enable clears itself once the receive flag is raised
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_q <= 1'b0;
      receive_flag_out <= 1'b0;
    end else begin
      receive_flag_out <= wake_q && !cfg.sync && rx_fall;
      if (receive_flag_out) begin
        wake_q <= 1'b0;
      end else if (wr_bc) begin
        wake_q <= wdata_in[SBRG_BC_WAKE];
      end
    end
  end

  // Idle follows the receiver; software polls it before clock moves
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_q <= 1'b1;
    end else begin
      idle_q <= !rx_busy_in;
    end
  end

  // ********************************************************
  // Software registers
  // ********************************************************

  // Baud control writable fields; bits 5 and 2 have no storage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      polarity_q <= 1'b0;
      wide_q <= 1'b0;
    end else if (wr_bc) begin
      polarity_q <= wdata_in[SBRG_BC_POL];
      wide_q <= wdata_in[SBRG_BC_WIDE];
    end
  end

  // Divisor pair; auto-baud result loads both halves
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_low_q <= SBRG_RST_REG;
      div_high_q <= SBRG_RST_REG;
    end else if (abd_done) begin
      div_low_q <= abd_result[7:0];
      div_high_q <= abd_result[15:8];
    end else if (wr_in) begin
      if (hit(addr_in, SBRG_ADDR_DIV_LOW)) begin
        div_low_q <= wdata_in;
      end
      if (hit(addr_in, SBRG_ADDR_DIV_HIGH)) begin
        div_high_q <= wdata_in;
      end
    end
  end

  // Status and control registers of receiver and transmitter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_status_q <= SBRG_RST_REG;
      tx_status_q <= SBRG_RST_REG;
    end else if (wr_in) begin
      if (hit(addr_in, SBRG_ADDR_RX_STATUS)) begin
        rx_status_q <= wdata_in;
      end
      if (hit(addr_in, SBRG_ADDR_TX_STATUS)) begin
        tx_status_q <= wdata_in;
      end
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  assign irq_set = {abd_overflow, abd_done, receive_flag_out};

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q &
        ~((wr_in && hit(addr_in, SBRG_ADDR_IRQ_STATUS)) ?
          wdata_in[2:0] : 3'h0));
    end
  end

  // Mask register, same layout as the status
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_mask_q <= 3'h0;
    end else if (wr_in && hit(addr_in, SBRG_ADDR_IRQ_MASK)) begin
      irq_mask_q <= wdata_in[2:0] & SBRG_IRQ_BITS;
    end
  end

  // Level interrupt; one cycle behind the status bits
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ********************************************************
  // Pin outputs
  // ********************************************************

  // Async inverts data on demand; sync passes the shift clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      transmit_clock_pin_out <= 1'b1;
      clk_rise_out <= 1'b0;
    end else begin
      if (cfg.sync) begin
        transmit_clock_pin_out <= sync_clk_in;
      end else begin
        transmit_clock_pin_out <= tx_data_in ^ cfg.polarity;
      end
      clk_rise_out <= cfg.sync && polarity_q;
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************

  // Data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        SBRG_ADDR_BAUD_CONTROL: begin
          rdata_out <= {abd_ovf_q, idle_q, 1'b0, polarity_q,
                        wide_q, 1'b0, wake_q, abd_en_q};
        end
        SBRG_ADDR_RX_STATUS: begin
          rdata_out <= rx_status_q;
        end
        SBRG_ADDR_DIV_LOW: begin
          rdata_out <= div_low_q;
        end
        SBRG_ADDR_DIV_HIGH: begin
          rdata_out <= div_high_q;
        end
        SBRG_ADDR_TX_STATUS: begin
          rdata_out <= tx_status_q;
        end
        SBRG_ADDR_IRQ_STATUS: begin
          rdata_out <= {5'h00, irq_stat_q};
        end
        SBRG_ADDR_IRQ_MASK: begin
          rdata_out <= {5'h00, irq_mask_q};
        end
        default: begin
          rdata_out <= 8'h00;
        end
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule // sbrg_top

// ===== test/sbrg_top_chk.sv
/*
  Checker of the baud rate generator top, bound to every sbrg_top instance.
  Assumes one clock domain and the register map of sbrg_pkg.
*/
module sbrg_top_chk
  import sbrg_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Serial side
  input wire logic rx_in,
  input wire logic rx_busy_in,
  input wire logic receive_flag_out,
  input wire logic tx_data_in,
  input wire logic sync_clk_in,
  input wire logic transmit_clock_pin_out,
  input wire logic clk_rise_out,
  input wire logic baud_tick_out,
  input wire logic irq_out
);
  logic pol_q;
  logic spen_q;
  logic [7:0] txs_q;
  logic sync_mode;

  // Shadow of the mode bits, updated on the same edge as the design's registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pol_q <= 1'b0;
      spen_q <= 1'b0;
      txs_q <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == SBRG_ADDR_BAUD_CONTROL) pol_q <= wdata_in[SBRG_BC_POL];
      if (addr_in == SBRG_ADDR_RX_STATUS) spen_q <= wdata_in[SBRG_RC_SPEN];
      if (addr_in == SBRG_ADDR_TX_STATUS) txs_q <= wdata_in;
    end
  end
  assign sync_mode = txs_q[SBRG_TX_SYNC];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ********************************************************
  // Properties
  // ********************************************************
  bc_unimpl_a: assert property (rd_in && addr_in == SBRG_ADDR_BAUD_CONTROL |=>
    rdata_out[5] == 1'b0 && rdata_out[2] == 1'b0) else $error("reserved bit reads one");
  bc_idle_a: assert property (rd_in && addr_in == SBRG_ADDR_BAUD_CONTROL &&
    $stable(rx_busy_in) |=> rdata_out[6] == !$past(rx_busy_in)) else $error("idle flag wrong");
  txs_read_a: assert property (rd_in && addr_in == SBRG_ADDR_TX_STATUS |=>
    rdata_out == $past(txs_q)) else $error("mode register readback wrong");
  pin_async_a: assert property (!$past(sync_mode) |->
    transmit_clock_pin_out == ($past(tx_data_in) ^ $past(pol_q))) else $error("async pin wrong");
  pin_sync_a: assert property ($past(sync_mode) |->
    transmit_clock_pin_out == $past(sync_clk_in)) else $error("sync pin wrong");
  clk_rise_a: assert property (clk_rise_out == $past(sync_mode && pol_q))
    else $error("clock edge select wrong");
  tick_off_a: assert property ((!spen_q) [*3] |-> !baud_tick_out)
    else $error("tick while port disabled");
  div_clear_a: assert property (wr_in && (addr_in == SBRG_ADDR_DIV_LOW ||
    addr_in == SBRG_ADDR_DIV_HIGH) |-> ##2 (!baud_tick_out) [*3]) else $error("timer not cleared");
  tick_pulse_a: assert property (baud_tick_out |=> !baud_tick_out)
    else $error("tick longer than one cycle");
  flag_pulse_a: assert property (receive_flag_out |=> !receive_flag_out)
    else $error("receive flag longer than one cycle");
  flag_cause_a: assert property ($rose(receive_flag_out) |-> !$past(rx_in))
    else $error("receive flag without falling line");

  // Main scenarios reached
  cover property (baud_tick_out);
  cover property (receive_flag_out);
  cover property (clk_rise_out && transmit_clock_pin_out);
  cover property (irq_out);
endmodule // sbrg_top_chk

bind sbrg_top sbrg_top_chk chk_i (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .rx_in, .rx_busy_in, .receive_flag_out, .tx_data_in, .sync_clk_in,
  .transmit_clock_pin_out, .clk_rise_out, .baud_tick_out, .irq_out);

// ===== test/testbench.sv
/*
  Self-checking bench of the baud rate generator top.
  Assumes sbrg_pkg, the design and the checker file are compiled before it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sbrg_pkg::*;
  logic clk_in, nrst_in, wr_in, rd_in, rx_in, rx_busy_in, tx_data_in, sync_clk_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out;
  logic receive_flag_out, transmit_clock_pin_out, clk_rise_out, baud_tick_out, irq_out;
  int num_errors = 0;
  int comparisons = 0;

  sbrg_top dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_in,
    .rx_busy_in, .receive_flag_out, .tx_data_in, .sync_clk_in, .transmit_clock_pin_out,
    .clk_rise_out, .baud_tick_out, .irq_out);

  // 50 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ********************************************************
  // Bus and compare tasks
  // ********************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taken edge
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(16'(rdata_out), 16'(exp));
  endtask

  // Cycles up to the next tick, bounded so a dead timer cannot hang the run
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      #1 k++;
    end while (baud_tick_out !== 1'b1 && k < 3000);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_regs();
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h40);
    wr(SBRG_ADDR_BAUD_CONTROL, 8'hfc);
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h58);
    wr(SBRG_ADDR_BAUD_CONTROL, 8'h00);
    wr(3'h7, 8'hff);
    rchk(3'h7, 8'h00);
    @(posedge clk_in);
    rx_busy_in <= 1'b1;
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h00);
    @(posedge clk_in);
    rx_busy_in <= 1'b0;
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h40);
  endtask

  // Timer keeps running from earlier writes, so the first gap shows the clear
  task automatic t_rate(input logic [7:0] bc, txs, hi, lo, input int m);
    int k;
    int n;
    n = bc[SBRG_BC_WIDE] ? int'({hi, lo}) : int'(lo);
    wr(SBRG_ADDR_RX_STATUS, 8'h80);
    wr(SBRG_ADDR_BAUD_CONTROL, bc);
    wr(SBRG_ADDR_TX_STATUS, txs);
    wr(SBRG_ADDR_DIV_HIGH, hi);
    wr(SBRG_ADDR_DIV_LOW, lo);
    gap(k);
    chk(16'(k), 16'(m * (n + 1)));
    gap(k);
    chk(16'(k), 16'(m * (n + 1)));
    rchk(SBRG_ADDR_TX_STATUS, txs);
    rchk(SBRG_ADDR_DIV_HIGH, hi);
  endtask

  task automatic t_pin();
    for (int i = 0; i < 8; i++) begin
      wr(SBRG_ADDR_TX_STATUS, {3'h0, i[2], 4'h0});
      wr(SBRG_ADDR_BAUD_CONTROL, {3'h0, i[1], 4'h0});
      tx_data_in <= i[0];
      sync_clk_in <= ~i[0];
      repeat (2) @(posedge clk_in);
      #1 chk({clk_rise_out, transmit_clock_pin_out},
        {i[2] & i[1], i[2] ? ~i[0] : i[0] ^ i[1]});
    end
  endtask

  // Wake first with the source masked, then unmask, then clear
  task automatic t_wake();
    int k;
    wr(SBRG_ADDR_TX_STATUS, 8'h00);
    wr(SBRG_ADDR_BAUD_CONTROL, 8'h02);
    rx_in <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_in);
      #1 k++;
    end while (receive_flag_out !== 1'b1 && k < 10);
    chk(16'(k < 10), 16'h0001);
    @(posedge clk_in);
    rx_in <= 1'b1;
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h40);
    rchk(SBRG_ADDR_IRQ_STATUS, 8'h01);
    chk(16'(irq_out), 16'h0000);
    wr(SBRG_ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_in);
    #1 chk(16'(irq_out), 16'h0001);
    wr(SBRG_ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_in);
    #1 chk(16'(irq_out), 16'h0000);
  endtask

  // Calibration character of alternating bits gives five falling edges
  task automatic t_abd();
    wr(SBRG_ADDR_RX_STATUS, 8'h80);
    wr(SBRG_ADDR_BAUD_CONTROL, 8'h09);
    wr(SBRG_ADDR_TX_STATUS, 8'h04);
    for (int b = 0; b < 10; b++) begin
      rx_in <= b[0];
      repeat (16) @(posedge clk_in);
    end
    rchk(SBRG_ADDR_BAUD_CONTROL, 8'h48);
    rchk(SBRG_ADDR_IRQ_STATUS, 8'h02);
  endtask

  task automatic t_off();
    int hits;
    hits = 0;
    wr(SBRG_ADDR_RX_STATUS, 8'h00);
    repeat (4) @(posedge clk_in);
    repeat (300) begin
      @(posedge clk_in);
      #1 hits += int'(baud_tick_out !== 1'b0);
    end
    chk(16'(hits), 16'h0000);
  endtask

  // Watchdog well beyond the few thousand cycles the scenarios take
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  // Reset, then the scenarios in order
  initial begin
    {wr_in, rd_in, rx_busy_in, sync_clk_in} = 4'h0;
    {rx_in, tx_data_in} = 2'b11;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    nrst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_rate(8'h00, 8'h00, 8'h05, 8'h01, 64);
    t_rate(8'h08, 8'h00, 8'h00, 8'h02, 16);
    t_rate(8'h00, 8'h04, 8'h00, 8'h02, 16);
    t_rate(8'h08, 8'h04, 8'h01, 8'h00, 4);
    t_rate(8'h00, 8'h14, 8'h00, 8'h03, 4);
    t_pin();
    t_wake();
    t_abd();
    t_off();
    tally_and_finish();
  end
endmodule // testbench
